/* File: pkg/rail_seq_defs.svh */
// Functional notes
// - Filter time is filter count times 2us, or 10us with scale bit set.
// - Watch enable bit switches the external monitor; deep protect entry sets it.
// - Boost enable bit gates the boost rail; deep protect entry sets it.
// - Second buck enable bit gates that rail; deep protect entry sets it.
// - First buck enable bit gates that rail; deep protect entry sets it.
// - All-channel bit is a master enable for every rail output.
// - Ordered pin turn-on waits its field times the selected time base.
// - Boost rail turn-on waits its field times the selected time base.
// - Second buck turn-on waits its field times the selected time base.
// - First buck turn-on waits its field times the selected time base.
// - Time base codes 10 and 11 give 2.5ms and 5ms steps.
// - Watch reset map bit routes monitor faults onto the system reset.
// - Per-rail map bits 4..1 route rail faults onto the system reset.
// - System reset stays low 10 to 40ms after its cause clears.
// - With restart enabled, clearing all-channel bit resets registers, restarts.
`ifndef RAIL_SEQ_DEFS_SVH
`define RAIL_SEQ_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_FILTER_CFG 8'h03
`define ADDR_RAIL_EN 8'h05
`define ADDR_DELAY_A 8'h06
`define ADDR_DELAY_B 8'h07
`define ADDR_RESET_MAP 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLT_SCALE_BIT 5
`define EN_WATCH_BIT 5
`define EN_BOOST_BIT 4
`define EN_SECOND_BIT 3
`define EN_FIRST_BIT 2
`define EN_ALL_BIT 0
`define MAP_WATCH_BIT 5

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RST_FILTER_CFG 8'h00
`define RST_RAIL_EN 8'h3D
`define RST_DELAY_A 8'h00
`define RST_DELAY_B 8'h00
`define RST_RESET_MAP 8'h00
`define MASK_FILTER_CFG 8'h3F
`define MASK_RAIL_EN 8'h3D
`define MASK_RESET_MAP 8'h3E
`define DEEP_SET_EN 8'h3C

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define FLT_FINE_NS 2000
`define FLT_COARSE_NS 10000
`define FLT_FINE_CYC ((`FLT_FINE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLT_COARSE_CYC \
	((`FLT_COARSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_STEP0_US 500
`define DLY_STEP1_US 1000
`define DLY_STEP2_US 2500
`define DLY_STEP3_US 5000
`define US_TO_CYC(us) (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_STEP_MS 10
`define HOLD_STEP_CYC `US_TO_CYC(`HOLD_STEP_MS * 1000)

`endif

/* File: pkg/rail_seq_pkg.sv */
package rail_seq_pkg;

	// Register access strobes from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Enables handed to the power stages
	typedef struct packed {
		logic watch;
		logic boost;
		logic second_buck;
		logic first_buck;
		logic hv_buck;
		logic ordered_pin;
	} rail_on_s;

	typedef enum logic [2:0] {
		RST_IDLE = 3'b001,
		RST_FAULT = 3'b010,
		RST_HOLD = 3'b100
	} reset_state_e;

endpackage

/* File: core/fault_filter.sv */
`timescale 1ns/1ps
`default_nettype none

module fault_filter (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmp,
	input wire logic [8:0] step_cyc,
	input wire logic [4:0] lim,
	output logic flt
);

	logic [8:0] pre_r;
	logic [4:0] cnt_r;

	// Any drop of the comparator restarts the whole filter time
	always_ff @(posedge clk) begin
		if (!rstn || !cmp) begin
			pre_r <= 9'h000;
			cnt_r <= 5'h00;
		end else if (cnt_r < lim) begin
			if (pre_r == step_cyc - 9'h001) begin
				pre_r <= 9'h000;
				cnt_r <= cnt_r + 5'h01;
			end else begin
				pre_r <= pre_r + 9'h001;
			end
		end
	end

	// Zero count still costs one cycle, the output comes from a flop
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flt <= 1'b0;
		end else begin
			flt <= cmp && (cnt_r >= lim);
		end
	end

endmodule

`default_nettype wire

/* File: core/rail_seq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"

module rail_seq_ctrl #(
	parameter int unsigned DLY_STEP0_CYC = `US_TO_CYC(`DLY_STEP0_US),
	parameter int unsigned DLY_STEP1_CYC = `US_TO_CYC(`DLY_STEP1_US),
	parameter int unsigned DLY_STEP2_CYC = `US_TO_CYC(`DLY_STEP2_US),
	parameter int unsigned DLY_STEP3_CYC = `US_TO_CYC(`DLY_STEP3_US),
	parameter int unsigned HOLD_STEP_CYC = `HOLD_STEP_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire rail_seq_pkg::reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [4:0] ov_cmp,
	input wire logic [4:0] uv_cmp,
	input wire logic deep_protect_entry,
	input wire logic seq_start,
	input wire logic device_restart_enable,
	input wire logic [1:0] delay_scale,
	input wire logic [1:0] reset_hold_time_select,
	output rail_seq_pkg::rail_on_s rail_on,
	output logic [4:0] ov_filt,
	output logic [4:0] uv_filt,
	output logic system_reset_out_n,
	output logic device_restart
);
	import rail_seq_pkg::*;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] filter_cfg_r;
	logic [7:0] rail_en_r;
	logic [7:0] delay_a_r;
	logic [7:0] delay_b_r;
	logic [7:0] reset_map_r;
	logic restart_hit;
	logic wr_en;

	assign wr_en = reg_req.wr && (reg_req.addr == `ADDR_RAIL_EN);
	// Master bit going 1 to 0 while restart is armed
	assign restart_hit = wr_en && device_restart_enable &&
		rail_en_r[`EN_ALL_BIT] && !reg_req.wdata[`EN_ALL_BIT];

	// Plain configuration registers; restart puts them back to defaults
	always_ff @(posedge clk) begin
		if (!rstn || restart_hit) begin
			filter_cfg_r <= `RST_FILTER_CFG;
			delay_a_r <= `RST_DELAY_A;
			delay_b_r <= `RST_DELAY_B;
			reset_map_r <= `RST_RESET_MAP;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				`ADDR_FILTER_CFG: filter_cfg_r <=
					reg_req.wdata & `MASK_FILTER_CFG;
				`ADDR_DELAY_A: delay_a_r <= reg_req.wdata;
				`ADDR_DELAY_B: delay_b_r <= reg_req.wdata;
				`ADDR_RESET_MAP: reset_map_r <=
					reg_req.wdata & `MASK_RESET_MAP;
				default: ;
			endcase
		end
	end

	// Deep protect entry sets the enables after any write of the same
	// cycle, so the hardware set is never lost to software
	always_ff @(posedge clk) begin
		if (!rstn || restart_hit) begin
			rail_en_r <= `RST_RAIL_EN;
		end else if (deep_protect_entry) begin
			rail_en_r <= (wr_en ? (reg_req.wdata & `MASK_RAIL_EN) :
				rail_en_r) | `DEEP_SET_EN;
		end else if (wr_en) begin
			rail_en_r <= reg_req.wdata & `MASK_RAIL_EN;
		end
	end

	// Read data registered; unmapped offsets and reserved bits read zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				`ADDR_FILTER_CFG: reg_rdata <= filter_cfg_r;
				`ADDR_RAIL_EN: reg_rdata <= rail_en_r;
				`ADDR_DELAY_A: reg_rdata <= delay_a_r;
				`ADDR_DELAY_B: reg_rdata <= delay_b_r;
				`ADDR_RESET_MAP: reg_rdata <= reset_map_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Restart pulse to the power stages' own reset controller
	always_ff @(posedge clk) begin
		if (!rstn) begin
			device_restart <= 1'b0;
		end else begin
			device_restart <= restart_hit;
		end
	end

	// ----------------------------------------
	// Comparator filters
	// ----------------------------------------
	logic [8:0] flt_step;
	logic [9:0] cmp_all;
	logic [9:0] flt_all;

	assign flt_step = filter_cfg_r[`FLT_SCALE_BIT] ?
		9'(`FLT_COARSE_CYC) : 9'(`FLT_FINE_CYC);
	assign cmp_all = {uv_cmp, ov_cmp};
	assign ov_filt = flt_all[4:0];
	assign uv_filt = flt_all[9:5];

	// One filter per comparator, every one on the shared setting
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_flt
			fault_filter u_flt (
				.clk(clk),
				.rstn(rstn),
				.cmp(cmp_all[gi]),
				.step_cyc(flt_step),
				.lim(filter_cfg_r[4:0]),
				.flt(flt_all[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Turn-on delay timers
	// ----------------------------------------
	logic [17:0] step_cyc;
	logic [17:0] pre_r;
	logic [3:0] steps_r;
	logic seq_run_r;
	logic seq_go;

	// Time base step per scale code
	always_comb begin
		case (delay_scale)
			2'b00: step_cyc = 18'(DLY_STEP0_CYC);
			2'b01: step_cyc = 18'(DLY_STEP1_CYC);
			2'b10: step_cyc = 18'(DLY_STEP2_CYC);
			2'b11: step_cyc = 18'(DLY_STEP3_CYC);
			default: step_cyc = 18'(DLY_STEP0_CYC);
		endcase
	end

	// A restart counts as a new power-up sequence
	assign seq_go = seq_start || device_restart;

	// All timers share one start, so one step counter serves every rail
	always_ff @(posedge clk) begin
		if (!rstn || seq_go) begin
			pre_r <= 18'h00000;
			steps_r <= 4'h0;
		end else if (seq_run_r && steps_r != 4'hF) begin
			if (pre_r >= step_cyc - 18'h00001) begin
				pre_r <= 18'h00000;
				steps_r <= steps_r + 4'h1;
			end else begin
				pre_r <= pre_r + 18'h00001;
			end
		end
	end

	// Sequence stays running until deep protect or master disable
	always_ff @(posedge clk) begin
		if (!rstn) begin
			seq_run_r <= 1'b0;
		end else if (seq_go) begin
			seq_run_r <= 1'b1;
		end else if (deep_protect_entry || !rail_en_r[`EN_ALL_BIT]) begin
			seq_run_r <= 1'b0;
		end
	end

	// Rail enables: master bit and running sequence, then own bit and own wait where the rail has them
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rail_on <= '0;
		end else if (!rail_en_r[`EN_ALL_BIT] || !seq_run_r ||
			restart_hit || device_restart) begin
			// A restart drops every rail before the new sequence runs
			rail_on <= '0;
		end else begin
			rail_on.watch <= rail_en_r[`EN_WATCH_BIT];
			rail_on.hv_buck <= 1'b1;
			rail_on.ordered_pin <= steps_r >= delay_a_r[7:4];
			rail_on.boost <= rail_en_r[`EN_BOOST_BIT] &&
				steps_r >= delay_a_r[3:0];
			rail_on.second_buck <= rail_en_r[`EN_SECOND_BIT] &&
				steps_r >= delay_b_r[7:4];
			rail_on.first_buck <= rail_en_r[`EN_FIRST_BIT] &&
				steps_r >= delay_b_r[3:0];
		end
	end

	// ----------------------------------------
	// System reset output
	// ----------------------------------------
	logic [4:0] ch_fault;
	logic [4:0] map_bits;
	logic fault_any;
	logic [20:0] hold_lim;
	logic [20:0] hold_r;
	reset_state_e rst_state_r;

	assign ch_fault = ov_filt | uv_filt;
	assign map_bits = {reset_map_r[`MAP_WATCH_BIT], reset_map_r[4:1]};
	assign fault_any = |(ch_fault & map_bits);
	// Hold time is 10ms times one more than the select code
	assign hold_lim = 21'(HOLD_STEP_CYC * ({30'h0, reset_hold_time_select}
		+ 32'h1));

	// Low while a mapped fault stands, then held for the chosen time
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rst_state_r <= RST_IDLE;
			hold_r <= 21'h000000;
			system_reset_out_n <= 1'b1;
		end else begin
			case (rst_state_r)
				RST_IDLE: begin
					if (fault_any) begin
						rst_state_r <= RST_FAULT;
						system_reset_out_n <= 1'b0;
					end
				end
				RST_FAULT: begin
					hold_r <= 21'h000000;
					if (!fault_any) begin
						rst_state_r <= RST_HOLD;
					end
				end
				RST_HOLD: begin
					if (fault_any) begin
						rst_state_r <= RST_FAULT;
					end else if (hold_r >= hold_lim - 21'h000001) begin
						rst_state_r <= RST_IDLE;
						system_reset_out_n <= 1'b1;
					end else begin
						hold_r <= hold_r + 21'h000001;
					end
				end
				default: begin
					rst_state_r <= RST_IDLE;
					system_reset_out_n <= 1'b1;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

/* File: sim/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output var rail_seq_pkg::reg_req_s reg_req
);
	import rail_seq_pkg::*;
	// -----------------------------
	// Strobe driver
	// -----------------------------
	// Idle fields show inverted junk so stale values are never trusted
	initial reg_req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		reg_req = '{1'b0, 1'b0, ~a, ~d};
	endtask
	// Data lands one edge after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_req = '{1'b0, 1'b1, a, 8'hA5};
		@(negedge clk);
		reg_req = '{1'b0, 1'b0, ~a, 8'h5A};
		@(posedge clk);
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

/* File: sim/rail_seq_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rail_seq_ctrl_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire rail_seq_pkg::reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic [4:0] ov_cmp,
	input wire logic [4:0] uv_cmp,
	input wire logic deep_protect_entry,
	input wire logic seq_start,
	input wire rail_seq_pkg::rail_on_s rail_on,
	input wire logic [4:0] ov_filt,
	input wire logic [4:0] uv_filt,
	input wire logic system_reset_out_n,
	input wire logic device_restart
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Set once any sequence has begun; rails must stay dark before that
	logic started_r;
	always_ff @(posedge clk) begin
		if (!rstn) started_r <= 1'b0;
		else if (seq_start || device_restart) started_r <= 1'b1;
	end
	ov_filt_drop_a: assert property (1 |=>
		(ov_filt & ~$past(ov_cmp)) == 5'h00)
		else $error("ov filter passed a dropped comparator");
	uv_filt_drop_a: assert property (1 |=>
		(uv_filt & ~$past(uv_cmp)) == 5'h00)
		else $error("uv filter passed a dropped comparator");
	reset_cause_a: assert property ($fell(system_reset_out_n) |->
		$past(ov_filt | uv_filt) != 5'h00) else $error("reset without a fault");
	reset_hold_a: assert property ($rose(system_reset_out_n) |->
		$past(!system_reset_out_n, 8)) else $error("reset hold too short");
	restart_pulse_a: assert property (device_restart |=> !device_restart)
		else $error("restart pulse too long");
	deep_stop_a: assert property (deep_protect_entry ##1 !seq_start |=>
		rail_on == 6'h00) else $error("rails on after deep protect entry");
	no_early_rail_a: assert property (!started_r |-> rail_on == 6'h00)
		else $error("rail on before any sequence");
	read_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
endmodule
bind rail_seq_ctrl rail_seq_ctrl_checker chk (.clk(clk), .rstn(rstn),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .ov_cmp(ov_cmp),
	.uv_cmp(uv_cmp), .deep_protect_entry(deep_protect_entry),
	.seq_start(seq_start), .rail_on(rail_on), .ov_filt(ov_filt),
	.uv_filt(uv_filt), .system_reset_out_n(system_reset_out_n),
	.device_restart(device_restart));
`default_nettype wire

/* File: sim/tb_rail_seq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rail_seq_ctrl;
	import rail_seq_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, deep = 1'b0, seq = 1'b0, rst_en = 1'b0;
	logic [4:0] ov = '0, uv = '0, ovf, uvf;
	logic [1:0] dscale = '0, hsel = '0;
	logic [7:0] rdata, d;
	logic rst_n, restart;
	reg_req_s req;
	rail_on_s on;
	int fail_count = 0, total_checks = 0, t[4], n;
	int stp[4] = '{4, 6, 8, 10}, idx[4] = '{0, 4, 3, 2}, fld[4] = '{2, 1, 3, 0};
	logic [7:0] ad[5] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08};
	logic [7:0] df[5] = '{8'h00, 8'h3D, 8'h00, 8'h00, 8'h00};
	logic [7:0] mk[5] = '{8'h3F, 8'h3D, 8'hFF, 8'hFF, 8'h3E};
	host_model host (.clk(clk), .reg_rdata(rdata), .reg_req(req));
	rail_seq_ctrl #(.DLY_STEP0_CYC(4), .DLY_STEP1_CYC(6), .DLY_STEP2_CYC(8),
		.DLY_STEP3_CYC(10), .HOLD_STEP_CYC(10)) dut (.clk(clk), .rstn(rstn),
		.reg_req(req), .reg_rdata(rdata), .ov_cmp(ov), .uv_cmp(uv),
		.deep_protect_entry(deep), .seq_start(seq),
		.device_restart_enable(rst_en), .delay_scale(dscale),
		.reset_hold_time_select(hsel), .rail_on(on), .ov_filt(ovf),
		.uv_filt(uvf), .system_reset_out_n(rst_n), .device_restart(restart));
	// -----------------------------
	// Check helpers
	// -----------------------------
	task automatic summarize;
		if (fail_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Cycle counts get a small window; the exact edge is the designer's choice
	task automatic chk_rng(input int g, input int lo, input int hi);
		total_checks++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("[ERR] %0t count %0d not in %0d..%0d", $time, g, lo, hi);
			if (g < 0) summarize();
		end
	endtask
	// Waits at most 500 cycles for a settled flag: the first buck's
	// filtered over-voltage when w is 1, the system reset otherwise
	task automatic wait_for(input int w, input logic v, output int c);
		logic s;
		c = -1;
		for (int i = 1; i <= 500 && c < 0; i++) begin
			@(negedge clk);
			s = (w == 1) ? ovf[1] : rst_n;
			if (s === v) c = i;
		end
	endtask
	initial forever #12.5 clk = ~clk;
	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		// Defaults, then reserved bits dropped on write
		for (int i = 0; i < 5; i++) begin
			host.rd(ad[i], d);
			chk(d, df[i]);
			host.wr(ad[i], 8'hFF);
			host.rd(ad[i], d);
			chk(d, mk[i]);
		end
		host.wr(8'h04, 8'hFF);
		host.rd(8'h04, d);
		chk(d, 8'h00);
		host.wr(8'h03, 8'h00);
		host.wr(8'h05, 8'h01);
		@(negedge clk) deep = 1'b1;
		@(negedge clk) deep = 1'b0;
		host.rd(8'h05, d);
		chk(d, 8'h3D);
		// Turn-on waits under every time base; deep entry drops rails between
		host.wr(8'h06, 8'h21);
		host.wr(8'h07, 8'h30);
		for (int s = 0; s < 4; s++) begin
			dscale = s[1:0];
			@(negedge clk) deep = 1'b1;
			@(negedge clk) deep = 1'b0;
			repeat (3) @(negedge clk);
			seq = 1'b1;
			@(negedge clk) seq = 1'b0;
			t = '{-1, -1, -1, -1};
			for (int c = 1; c < 60; c++) begin
				@(negedge clk);
				for (int b = 0; b < 4; b++) begin
					if (t[b] < 0 && on[idx[b]] === 1'b1) begin
						t[b] = c;
					end
				end
			end
			for (int b = 0; b < 4; b++) begin
				n = fld[b] * stp[s] + 1;
				chk_rng(t[b], n, n + 2);
			end
		end
		host.wr(8'h05, 8'h3C);
		repeat (3) @(negedge clk);
		chk({2'b00, on}, 8'h00);
		rst_en = 1'b1;
		host.wr(8'h05, 8'h3D);
		// Rails running when the restart hits, so the shutdown is visible
		@(negedge clk) seq = 1'b1;
		@(negedge clk) seq = 1'b0;
		host.wr(8'h06, 8'h55);
		host.wr(8'h05, 8'h3C);
		// The restart pulse stands only in the cycle after the write edge
		chk({7'h00, restart}, 8'h01);
		chk({2'b00, on}, 8'h00);
		repeat (3) @(negedge clk);
		chk({2'b00, on}, 8'h3F);
		host.rd(8'h06, d);
		chk(d, 8'h00);
		// Filter length at both scales, then a glitch that restarts it
		for (int f = 0; f < 2; f++) begin
			host.wr(8'h03, f ? 8'h21 : 8'h01);
			ov[1] = 1'b1;
			wait_for(1, 1'b1, n);
			chk_rng(n, f ? 401 : 81, f ? 403 : 83);
			ov[1] = 1'b0;
		end
		host.wr(8'h03, 8'h01);
		ov[1] = 1'b1;
		repeat (40) @(negedge clk);
		ov[1] = 1'b0;
		@(negedge clk) ov[1] = 1'b1;
		repeat (50) @(negedge clk);
		chk({7'h00, ovf[1]}, 8'h00);
		ov[1] = 1'b0;
		// Reset mapping and hold time
		host.wr(8'h03, 8'h00);
		host.wr(8'h08, 8'h04);
		hsel = 2'b01;
		uv[2] = 1'b1;
		repeat (5) @(negedge clk);
		chk({7'h00, rst_n}, 8'h01);
		uv = 5'h02;
		repeat (5) @(negedge clk);
		chk({7'h00, rst_n}, 8'h00);
		uv = 5'h00;
		wait_for(2, 1'b1, n);
		chk_rng(n, 19, 26);
		uv[4] = 1'b1;
		repeat (5) @(negedge clk);
		chk({7'h00, rst_n}, 8'h01);
		host.wr(8'h08, 8'h20);
		repeat (5) @(negedge clk);
		chk({7'h00, rst_n}, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
